// file: verilog/exposure_trigger_sync.sv
// Exposure trigger and sync outputs of the camera, with AXI4-Lite registers
// Assumes trig_n is asynchronous; pixels are fed in only while sync_a is high
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`include "trig_sync_map.svh"
module exposure_trigger_sync #(
  parameter int PIX_W  = 12,
  parameter int LINE_W = 1024
) (
  // Clock, reset, enable
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // AXI4-Lite slave
  input  wire logic [`TS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [`TS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Trigger port
  input  wire logic                trig_n,
  output logic                     sync_a,
  output logic                     sync_b,
  // Pixel stream
  input  wire logic                pix_valid,
  input  wire logic [PIX_W-1:0]    pix_data,
  input  wire logic                pix_line_end,
  output logic                     bin_valid,
  output logic [PIX_W+1:0]         bin_data
);
  import trig_sync_pkg::*;

  // Register file
  logic [31:0] ctrl_reg;
  logic [31:0] exp_len_reg;
  logic [31:0] rd_len_reg;
  logic        sw_trig_reg;
  logic [15:0] frame_cnt_reg;

  // AXI state
  logic                  aw_hold_reg;
  logic                  w_hold_reg;
  logic [`TS_ADDR_W-1:0] awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic                  rvalid_reg;
  logic [1:0]            rresp_reg;
  logic [31:0]           rdata_reg;

  // Trigger path
  logic        trig_s1_reg;
  logic        trig_s2_reg;
  logic        trig_s3_reg;
  expo_state_t state_reg;
  expo_state_t state_next;
  logic [31:0] exp_cnt_reg;
  logic [31:0] rd_cnt_reg;
  logic [31:0] exp_seen_reg;
  logic        sync_a_reg;
  logic        sync_b_reg;

  // Control decode
  wire trig_mode_t  mode       = trig_mode_t'(ctrl_reg[`TS_CTRL_MODE_HI:`TS_CTRL_MODE_LO]);
  wire syncb_mode_t syncb_mode = syncb_mode_t'(ctrl_reg[`TS_CTRL_SYNCB]);
  wire logic        run        = ctrl_reg[`TS_CTRL_RUN];
  wire logic        edge_up    = ctrl_reg[`TS_CTRL_EDGE_UP];
  wire logic        pulse_hi   = ctrl_reg[`TS_CTRL_PULSE_HI];

  // Pin decode; a low pin reads as an asserted trigger by default
  wire logic pin_rise  = trig_s2_reg && !trig_s3_reg;
  wire logic pin_fall  = !trig_s2_reg && trig_s3_reg;
  wire logic edge_hit  = edge_up ? pin_rise : pin_fall;           // see R1 see R9
  wire logic level_on  = pulse_hi ? trig_s2_reg : !trig_s2_reg;   // see R1 see R10
  wire logic idle      = state_reg == ST_IDLE;

  // Only the idle state listens; edge and software triggers outside it are dropped, a pulse level still held starts on return to idle
  wire logic start_hit =
      (mode == MODE_CONTINUAL) ||
      (mode == MODE_EDGE     && edge_hit) ||
      (mode == MODE_PULSE    && level_on) ||
      (mode == MODE_SOFTWARE && sw_trig_reg);                     // see R5
  wire logic exp_done  = (mode == MODE_PULSE) ? !level_on         // see R10
                                              : exp_cnt_reg <= 32'h0000_0001; // see R6
  wire logic rd_done   = rd_cnt_reg <= 32'h0000_0001;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:    if (run && start_hit) state_next = ST_EXPOSE;
      ST_EXPOSE:  if (exp_done)         state_next = ST_READOUT;  // see R6
      ST_READOUT: if (rd_done)          state_next = ST_IDLE;
      default:                          state_next = ST_IDLE;
    endcase
  end

  // Two flops before anything reads the pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trig_s1_reg <= 1'b1;
      trig_s2_reg <= 1'b1;
      trig_s3_reg <= 1'b1;
    end
    else if (ce)
    begin
      trig_s1_reg <= trig_n;      // see R11
      trig_s2_reg <= trig_s1_reg; // see R11
      trig_s3_reg <= trig_s2_reg;
    end
  end

  wire logic        to_expose = idle && state_next == ST_EXPOSE;
  wire logic        to_read   = state_reg == ST_EXPOSE && state_next == ST_READOUT;
  wire logic [31:0] exp_load  = (exp_len_reg == '0) ? 32'h0000_0001 : exp_len_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg     <= ST_IDLE;
      exp_cnt_reg   <= '0;
      rd_cnt_reg    <= '0;
      exp_seen_reg  <= '0;
      frame_cnt_reg <= '0;
      sync_a_reg    <= 1'b0;
      sync_b_reg    <= 1'b0;
    end
    else if (ce)
    begin
      state_reg    <= state_next;
      exp_cnt_reg  <= to_expose ? exp_load : exp_cnt_reg - 32'h0000_0001;
      exp_seen_reg <= to_expose ? 32'h0000_0001 : exp_seen_reg + 32'h0000_0001;
      rd_cnt_reg   <= to_read ? rd_len_reg : rd_cnt_reg - 32'h0000_0001;
      if (state_reg == ST_READOUT && rd_done)
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      sync_a_reg   <= state_next == ST_READOUT;                            // see R2
      sync_b_reg   <= (syncb_mode == SYNCB_EXPOSE) ? state_next == ST_EXPOSE // see R3 see R4
                                                   : state_next != ST_IDLE;  // see R5
    end
  end

  assign sync_a = sync_a_reg;
  assign sync_b = sync_b_reg;

  // AXI4-Lite: address and data may arrive in either order
  wire logic do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire logic wr_ok    = awaddr_reg == `TS_OFF_CTRL || awaddr_reg == `TS_OFF_EXPOSURE ||
                        awaddr_reg == `TS_OFF_READOUT || awaddr_reg == `TS_OFF_SWTRIG;
  wire logic [31:0] wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                             {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire logic rd_take  = s_axi_arvalid && s_axi_arready;
  wire logic [31:0] status_word = {frame_cnt_reg, 13'h0000, trig_s2_reg, state_reg};

  assign s_axi_awready = ce && !aw_hold_reg;
  assign s_axi_wready  = ce && !w_hold_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ce && !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TS_RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_ok ? `TS_RESP_OKAY : `TS_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg  <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg    <= `TS_RST_CTRL;
      exp_len_reg <= `TS_RST_EXPOSURE;
      rd_len_reg  <= `TS_RST_READOUT;
      sw_trig_reg <= 1'b0;
    end
    else if (ce)
    begin
      sw_trig_reg <= do_write && awaddr_reg == `TS_OFF_SWTRIG && wstrb_reg[0] && wdata_reg[0];
      if (do_write && awaddr_reg == `TS_OFF_CTRL)
        ctrl_reg <= (ctrl_reg & ~wmask) | (wdata_reg & wmask & 32'h0000_007F); // see R3
      if (do_write && awaddr_reg == `TS_OFF_EXPOSURE)
        exp_len_reg <= (exp_len_reg & ~wmask) | (wdata_reg & wmask);
      if (do_write && awaddr_reg == `TS_OFF_READOUT)
        rd_len_reg <= (rd_len_reg & ~wmask) | (wdata_reg & wmask);
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= `TS_RESP_OKAY;
      rdata_reg  <= '0;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= `TS_RESP_OKAY;
        unique case (s_axi_araddr)
          `TS_OFF_CTRL:     rdata_reg <= ctrl_reg;
          `TS_OFF_EXPOSURE: rdata_reg <= exp_len_reg;
          `TS_OFF_READOUT:  rdata_reg <= rd_len_reg;
          `TS_OFF_SWTRIG:   rdata_reg <= '0;
          `TS_OFF_STATUS:   rdata_reg <= status_word;
          default:
          begin
            rdata_reg <= '0;
            rresp_reg <= `TS_RESP_SLVERR;
          end
        endcase
      end
      else if (rvalid_reg && s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  // Binning runs only on the pixels of a readout
  bin_if #(.PIX_W(PIX_W)) bus ();
  assign bus.in_valid    = pix_valid && sync_a_reg;
  assign bus.in_data     = pix_data;
  assign bus.in_line_end = pix_line_end;
  assign bus.frame_start = to_read;
  assign bus.bin_en      = ctrl_reg[`TS_CTRL_BIN];
  assign bin_valid       = bus.out_valid;
  assign bin_data        = bus.out_data;

  pixel_binner #(.PIX_W(PIX_W), .LINE_W(LINE_W)) binner_u (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .bp      (bus.binner)
  );

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_read_start;
    ce && to_read;
  endsequence

  chk_readout_flag: assert property ( // see R2
    (state_reg == ST_READOUT) == sync_a)
    else $error("sync_a does not match readout");

  // The output is registered, so it follows a mode change one cycle late
  chk_expose_flag: assert property ( // see R4
    $past(syncb_mode) == SYNCB_EXPOSE |-> sync_b == (state_reg == ST_EXPOSE))
    else $error("sync_b does not mark exposure");

  chk_reject_flag: assert property ( // see R5
    $past(syncb_mode) == SYNCB_REJECT |-> sync_b == !idle)
    else $error("sync_b does not mark trigger reject");

  chk_reject_ignore: assert property ( // see R5
    (ce && state_reg == ST_READOUT && !rd_done) |=> state_reg == ST_READOUT)
    else $error("readout left early");

  chk_exposure_len: assert property ( // see R6
    (s_read_start and (mode != MODE_PULSE)) |-> exp_seen_reg == exp_load)
    else $error("internal exposure length wrong");

  chk_readout_follows: assert property ( // see R6
    s_read_start |=> sync_a)
    else $error("readout did not follow exposure");

  chk_edge_start: assert property ( // see R9 see R1
    (ce && idle && run && mode == MODE_EDGE && edge_hit) |=> state_reg == ST_EXPOSE && !sync_a)
    else $error("edge trigger did not start exposure");

  chk_pulse_end: assert property ( // see R10
    (ce && state_reg == ST_EXPOSE && mode == MODE_PULSE && !level_on)
      |=> state_reg == ST_READOUT)
    else $error("pulse exposure did not end with the pin");

  chk_sync_delay: assert property ( // see R11
    ce |=> trig_s2_reg == $past(trig_s1_reg) && trig_s1_reg == $past(trig_n))
    else $error("pin did not pass two synchroniser stages");
endmodule

// file: common/trig_sync_map.svh
// Register offsets, field positions, reset values for the exposure trigger block
// Assumes a 32-bit AXI4-Lite register bus; byte addresses, one word per register
//
// Behaviour
// R1 - The trigger pin is active low: a low level, or the change to low, is a trigger.
// R2 - The readout output is high for the whole sensor readout and low at all other times.
// R3 - The second sync output has two modes, chosen by a software-written setting.
// R4 - In exposure mode the second sync output is high for the whole of each exposure.
// R5 - In reject mode it is high while a trigger would be refused, and such triggers are ignored.
// R6 - With internal timing, exposure lasts exactly the programmed length, then readout follows; the code times a length of 0 as one cycle.
// R7 - With binning on, 2x2 neighbouring pixels are summed into one output pixel.
// R8 - The trigger source should wait for the readout output to fall before the next trigger.
// R9 - In edge mode exposure starts on the chosen edge of the pin and is timed internally.
// R10 - In pulse mode exposure lasts exactly as long as the pin stays at the chosen level.
// R11 - The trigger pin passes a two-stage synchroniser before any edge or level detection.
`ifndef TRIG_SYNC_MAP_SVH
`define TRIG_SYNC_MAP_SVH

`define TS_ADDR_W        6
`define TS_OFF_CTRL      6'h00
`define TS_OFF_EXPOSURE  6'h04
`define TS_OFF_READOUT   6'h08
`define TS_OFF_SWTRIG    6'h0C
`define TS_OFF_STATUS    6'h10

`define TS_CTRL_RUN      0
`define TS_CTRL_MODE_LO  1
`define TS_CTRL_MODE_HI  2
`define TS_CTRL_EDGE_UP  3
`define TS_CTRL_PULSE_HI 4
`define TS_CTRL_SYNCB    5
`define TS_CTRL_BIN      6

`define TS_STAT_ST_LO    0
`define TS_STAT_ST_HI    1
`define TS_STAT_PIN      2
`define TS_STAT_FRM_LO   16

`define TS_RST_CTRL      32'h0000_0000
`define TS_RST_EXPOSURE  32'h0000_0064
`define TS_RST_READOUT   32'h0000_0100

`define TS_RESP_OKAY     2'h0
`define TS_RESP_SLVERR   2'h2

`endif

// file: common/trig_sync_pkg.sv
// Types shared by the exposure trigger core and the pixel binner
// Assumes trig_sync_map.svh supplies all numeric constants
package trig_sync_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'b00,
    ST_EXPOSE  = 2'b01,
    ST_READOUT = 2'b11
  } expo_state_t;

  typedef enum logic [1:0]
  {
    MODE_CONTINUAL = 2'b00,
    MODE_EDGE      = 2'b01,
    MODE_PULSE     = 2'b10,
    MODE_SOFTWARE  = 2'b11
  } trig_mode_t;

  typedef enum logic
  {
    SYNCB_EXPOSE = 1'b0,
    SYNCB_REJECT = 1'b1
  } syncb_mode_t;

endpackage

// file: common/bin_if.sv
// Pixel path between the trigger core and the binner
// Assumes both ends run on the same clock and clock enable
interface bin_if #(parameter int PIX_W = 12);
  logic             in_valid;
  logic [PIX_W-1:0] in_data;
  logic             in_line_end;
  logic             frame_start;
  logic             bin_en;
  logic             out_valid;
  logic [PIX_W+1:0] out_data;

  modport core   (output in_valid, in_data, in_line_end, frame_start, bin_en,
                  input  out_valid, out_data);
  modport binner (input  in_valid, in_data, in_line_end, frame_start, bin_en,
                  output out_valid, out_data);
endinterface

// file: verilog/pixel_binner.sv
// 2x2 pixel binner with a one-line buffer of horizontal pair sums
// Assumes pixels arrive in raster order, an even count per line, line_end on the last
module pixel_binner #(
  parameter int PIX_W  = 12,
  parameter int LINE_W = 1024
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Pixel path
  bin_if.binner    bp
);
  import trig_sync_pkg::*;

  localparam int PAIRS = LINE_W / 2;
  localparam int COL_W = $clog2(PAIRS);

  logic [PIX_W:0]   line_mem [PAIRS];
  logic [COL_W-1:0] col_reg;
  logic             odd_col_reg;
  logic             odd_row_reg;
  logic [PIX_W-1:0] first_reg;
  logic             out_valid_reg;
  logic [PIX_W+1:0] out_data_reg;

  wire logic             take     = ce && bp.in_valid;
  wire logic             pair_end = bp.bin_en && odd_col_reg;
  wire logic [PIX_W:0]   h_sum    = {1'b0, first_reg} + {1'b0, bp.in_data};
  wire logic [PIX_W+1:0] v_sum    = {1'b0, line_mem[col_reg]} + {1'b0, h_sum};
  wire logic             emit     = take && (!bp.bin_en || (pair_end && odd_row_reg));

  assign bp.out_valid = out_valid_reg;
  assign bp.out_data  = out_data_reg;

  // Even rows park pair sums; odd rows add them back, so one output per 2x2 block
  always_ff @(posedge aclk)
  begin
    if (take && pair_end && !odd_row_reg)
      line_mem[col_reg] <= h_sum; // see R7
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else if (ce)
    begin
      out_valid_reg <= emit;
      if (emit)
        out_data_reg <= bp.bin_en ? v_sum : {2'b00, bp.in_data}; // see R7
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || (ce && bp.frame_start))
    begin
      col_reg     <= '0;
      odd_col_reg <= 1'b0;
      odd_row_reg <= 1'b0;
      first_reg   <= '0;
    end
    else if (take && bp.in_line_end)
    begin
      col_reg     <= '0;
      odd_col_reg <= 1'b0;
      odd_row_reg <= bp.bin_en && !odd_row_reg;
    end
    else if (take && bp.bin_en)
    begin
      odd_col_reg <= !odd_col_reg;
      if (!odd_col_reg)
        first_reg <= bp.in_data;
      else
        col_reg <= col_reg + COL_W'(1);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_bin_pass: assert property ( // see R7
    (ce && bp.in_valid && !bp.bin_en)
      |=> (bp.out_valid && bp.out_data == {2'b00, $past(bp.in_data)}))
    else $error("unbinned pixel not passed through");

  chk_bin_even_row: assert property ( // see R7
    (ce && bp.in_valid && bp.bin_en && !odd_row_reg) |=> !bp.out_valid)
    else $error("binned output on an even row");
endmodule

// file: testbench/trig_source.sv
// Model of the external trigger source driving the active-low trigger pin
// Assumes the bench calls its tasks just after a rising edge of aclk
module trig_source (
  // Clock and readout flag
  input  wire logic aclk,
  input  wire logic sync_a,
  // Trigger pin
  output logic      trig_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pin idles high; a trigger pulls it low
  initial trig_n = 1'b1;

  task automatic rest(input logic lvl);
    @(posedge aclk);
    trig_n <= lvl;
  endtask

  // Drive lvl for width cycles, then return to the opposite level
  task automatic pulse(input logic lvl, input int width, input bit obey);
    int n;
    n = 0;
    // A polite source waits for readout to end; obey=0 provokes a refused trigger
    while (obey && sync_a === 1'b1 && n < 1000)
    begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    trig_n <= lvl;
    repeat (width) @(posedge aclk);
    trig_n <= ~lvl;
  endtask
endmodule

// file: testbench/exposure_trigger_sync_bench.sv
// Self-checking bench: registers, every trigger mode, binning, mid-run reset
// Assumes trig_source models the trigger pin and trig_sync_map.svh is on the include path
`include "trig_sync_map.svh"
module exposure_trigger_sync_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import trig_sync_pkg::*;

  typedef struct packed {logic wr; logic [5:0] a; logic [31:0] d, exp; logic [1:0] resp;} reg_row_t;
  typedef struct packed {
    logic [6:0] ctrl; logic sw, idle, extra; logic [7:0] width, eb, ea; logic [1:0] fr;
  } frame_row_t;

  logic        aclk, aresetn, ce, trig_n, sync_a, sync_b;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, d0, b_run, b_len, a_run, a_len;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        pix_valid, pix_line_end, bin_valid;
  logic [11:0] pix_data;
  logic [13:0] bin_data;
  logic [13:0] bin_q[$];
  int          mismatches, checked, a_falls, falls, n;
  frame_row_t  f;

  localparam reg_row_t regs[14] = '{
    '{1'b0, `TS_OFF_CTRL, 32'h0, `TS_RST_CTRL, `TS_RESP_OKAY},
    '{1'b0, `TS_OFF_EXPOSURE, 32'h0, `TS_RST_EXPOSURE, `TS_RESP_OKAY},
    '{1'b0, `TS_OFF_READOUT, 32'h0, `TS_RST_READOUT, `TS_RESP_OKAY},
    '{1'b0, `TS_OFF_STATUS, 32'h0, 32'h0000_0004, `TS_RESP_OKAY},
    '{1'b0, 6'h14, 32'h0, 32'h0000_0000, `TS_RESP_SLVERR},
    '{1'b1, `TS_OFF_EXPOSURE, 32'h0000_0003, 32'h0, `TS_RESP_OKAY},
    '{1'b0, `TS_OFF_EXPOSURE, 32'h0, 32'h0000_0003, `TS_RESP_OKAY},
    '{1'b1, `TS_OFF_READOUT, 32'h0000_0004, 32'h0, `TS_RESP_OKAY},
    '{1'b0, `TS_OFF_READOUT, 32'h0, 32'h0000_0004, `TS_RESP_OKAY},
    '{1'b1, `TS_OFF_STATUS, 32'h0000_FFFF, 32'h0, `TS_RESP_SLVERR},
    '{1'b0, `TS_OFF_STATUS, 32'h0, 32'h0000_0004, `TS_RESP_OKAY},
    '{1'b1, 6'h18, 32'h0000_0001, 32'h0, `TS_RESP_SLVERR},
    '{1'b1, `TS_OFF_CTRL, 32'hFFFF_FF80, 32'h0, `TS_RESP_OKAY},
    '{1'b0, `TS_OFF_CTRL, 32'h0, 32'h0000_0000, `TS_RESP_OKAY}};

  // Exposure 3 and readout 4 cycles; ctrl = run, mode, edge up, pulse high, reject
  localparam frame_row_t frames[7] = '{
    '{7'h01, 1'b0, 1'b1, 1'b0, 8'h00, 8'h03, 8'h04, 2'h0},
    '{7'h03, 1'b0, 1'b1, 1'b0, 8'h0A, 8'h03, 8'h04, 2'h1},
    '{7'h0B, 1'b0, 1'b1, 1'b0, 8'h0A, 8'h03, 8'h04, 2'h1},
    '{7'h05, 1'b0, 1'b1, 1'b0, 8'h06, 8'h06, 8'h04, 2'h1},
    '{7'h15, 1'b0, 1'b0, 1'b0, 8'h06, 8'h06, 8'h04, 2'h1},
    '{7'h07, 1'b1, 1'b1, 1'b0, 8'h00, 8'h03, 8'h04, 2'h1},
    '{7'h23, 1'b0, 1'b1, 1'b1, 8'h02, 8'h07, 8'h04, 2'h1}};

  localparam logic [11:0] pix[8] = '{12'hFFF, 12'hFFF, 12'h001, 12'h002,
                                     12'hFFF, 12'hFFF, 12'h010, 12'h020};
  localparam logic [13:0] bexp[2] = '{14'h3FFC, 14'h0033};

  exposure_trigger_sync exposure_trigger_sync_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .trig_n(trig_n),
    .sync_a(sync_a), .sync_b(sync_b), .pix_valid(pix_valid), .pix_data(pix_data),
    .pix_line_end(pix_line_end), .bin_valid(bin_valid), .bin_data(bin_data));

  trig_source trig_source_i (.aclk(aclk), .sync_a(sync_a), .trig_n(trig_n));

  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // Run lengths of both sync outputs, latched when each falls
  always @(posedge aclk)
  begin
    if (sync_b === 1'b1)
      b_run <= b_run + 1;
    else if (b_run != 0)
    begin
      b_len <= b_run;
      b_run <= 0;
    end
    if (sync_a === 1'b1)
      a_run <= a_run + 1;
    else if (a_run != 0)
    begin
      a_len <= a_run;
      a_run <= 0;
      a_falls++;
    end
    if (bin_valid === 1'b1)
      bin_q.push_back(bin_data);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic axi_write(input logic [5:0] a, input logic [31:0] wd, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= wd;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 || ++k > 100)
        break;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k > 100)
      mismatches++;
  endtask

  task automatic axi_read(input logic [5:0] a, output logic [31:0] rd, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 || ++k > 100)
        break;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k > 100)
      mismatches++;
  endtask

  task automatic wait_fall(input int base);
    int k;
    k = 0;
    while (a_falls == base && k++ < 500) @(posedge aclk);
    if (a_falls == base)
      mismatches++;
  endtask

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    complete_run;
  end

  initial
  begin
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, pix_valid, pix_data, pix_line_end} = '0;
    {b_run, b_len, a_run, a_len} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i])
    begin
      if (regs[i].wr)
        axi_write(regs[i].a, regs[i].d, r);
      else
        axi_read(regs[i].a, d, r);
      if (!regs[i].wr)
        check("rdata", d, regs[i].exp);
      check("resp", 32'(r), 32'(regs[i].resp));
    end
    $display("Register test done");
    foreach (frames[i])
    begin
      f = frames[i];
      trig_source_i.rest(f.idle);
      repeat (4) @(posedge aclk);
      axi_read(`TS_OFF_STATUS, d0, r);
      falls = a_falls;
      axi_write(`TS_OFF_CTRL, 32'(f.ctrl), r);
      if (f.sw)
        axi_write(`TS_OFF_SWTRIG, 32'h0000_0001, r);
      else if (f.width != 0)
        trig_source_i.pulse(~f.idle, int'(f.width), 1'b1);
      if (f.extra)
        trig_source_i.pulse(~f.idle, 2, 1'b0);
      wait_fall(falls);
      axi_write(`TS_OFF_CTRL, 32'h0000_0000, r);
      repeat (30) @(posedge aclk);
      check("sync_b length", b_len, 32'(f.eb));
      check("sync_a length", a_len, 32'(f.ea));
      axi_read(`TS_OFF_STATUS, d, r);
      if (f.fr != 0)
        check("frame count", 32'(d[31:16] - d0[31:16]), 32'(f.fr));
      $display("Frame test %0d done", i);
    end
    // Binning off then on, with a longer readout to carry two lines
    axi_write(`TS_OFF_READOUT, 32'h0000_0014, r);
    for (int b = 0; b < 2; b++)
    begin
      axi_write(`TS_OFF_CTRL, b ? 32'h0000_0043 : 32'h0000_0003, r);
      bin_q.delete();
      falls = a_falls;
      trig_source_i.pulse(1'b0, 2, 1'b1);
      n = 0;
      while (sync_a !== 1'b1 && n++ < 100) @(posedge aclk);
      foreach (pix[k])
      begin
        pix_valid <= 1'b1;
        pix_data <= pix[k];
        pix_line_end <= (k % 4 == 3);
        @(posedge aclk);
      end
      pix_valid <= 1'b0;
      pix_line_end <= 1'b0;
      wait_fall(falls);
      axi_write(`TS_OFF_CTRL, 32'h0000_0000, r);
      check("bin count", 32'(bin_q.size()), b ? 32'h0000_0002 : 32'h0000_0008);
      for (int k = 0; k < (b ? 2 : 8); k++)
        check("bin pixel", 32'(bin_q[k]), b ? 32'(bexp[k]) : 32'(pix[k]));
      $display("Binning test %0d done", b);
    end
    // Reset in mid-exposure drops both outputs and restores the registers
    axi_write(`TS_OFF_CTRL, 32'h0000_0003, r);
    trig_source_i.pulse(1'b0, 2, 1'b1);
    n = 0;
    while (sync_b !== 1'b1 && n++ < 100) @(posedge aclk);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("sync_a after reset", 32'(sync_a), 32'h0000_0000);
    check("sync_b after reset", 32'(sync_b), 32'h0000_0000);
    axi_read(`TS_OFF_EXPOSURE, d, r);
    check("exposure after reset", d, `TS_RST_EXPOSURE);
    axi_read(`TS_OFF_STATUS, d, r);
    check("state after reset", 32'(d[1:0]), 32'(ST_IDLE));
    $display("Reset test done");
    complete_run;
  end
endmodule
